/* rtl/cap_checker.sv */
// command/address parity checker with hold line and alert sequencing
// assumes the command fields are synchronous to CLK, sampled when chip select low
// Operation
// - check only while delay lock loop enabled
// - hold each selected command parity latency clocks
// - parity covers command, address, bank, stack bits
// - unused address inputs count as zero
// - even parity; odd total flags error
// - drop failing command; uncertain window may drop
// - parity error clears write crc error bit
// - log failing command and address bits
// - status bit set before alert releases
// - alert low within onset time
// - no execution during alert, except the command at the tap in its first cycle; precharge after row time
// - release alert after min width and precharge
// - suspend checking until status cleared, unless persistent
// - keep first log until status cleared; later errors do not overwrite it
// - status clear-only; latency write-only; log read-only
// - persistent mode resumes checking after alert
// - persistent alert pulse within width limits
// - parity latency added to read/write latency
module cap_checker #(
   parameter int USED_ADDR = 14,                 // connected plain address bits
   parameter int USE_STACK = 1                   // stack bits connected
) (
   input  wire logic              CLK,
   input  wire logic              RSTN,
   input  wire logic              CE,
   input  wire logic              DLL_ON,
   input  wire logic              CS_N,
   input  wire cap_pkg::cap_cmd_t CMD,
   input  wire logic              PARITY_INPUT,
   input  wire logic [2:0]        PARITY_LATENCY,
   input  wire logic              PERSIST,
   input  wire logic              STATUS_WR,
   input  wire logic              STATUS_WDATA,
   input  wire logic              CRC_ON,
   output logic                   EXEC_VALID,
   output cap_pkg::cap_cmd_t      EXEC_CMD,
   output logic                   ALERT_N,
   output logic                   PARITY_STATUS,
   output logic                   CRC_ERR_CLEAR,
   output logic                   PRECHARGE_ALL,
   output cap_pkg::cap_cmd_t      LOG_CMD,
   output logic [3:0]             LAT_ADD
);
   // ************************************************************
   // elaboration checks
   // ************************************************************
   initial begin
      if (USED_ADDR < 1 || USED_ADDR > cap_pkg::ADDR_W)
         $error("used address width out of range");
      if (cap_pkg::PW_MAX_CYC >= (1 << cap_pkg::CNT_W))
         $error("alert timer too narrow");
   end

   localparam logic [cap_pkg::CNT_W-1:0] ON_C  = cap_pkg::CNT_W'(cap_pkg::ALERT_ON_CYC);
   localparam logic [cap_pkg::CNT_W-1:0] MIN_C = cap_pkg::CNT_W'(cap_pkg::ALERT_ON_CYC + cap_pkg::PW_MIN_CYC);
   localparam logic [cap_pkg::CNT_W-1:0] ROW_C = cap_pkg::CNT_W'(cap_pkg::ROW_MIN_CYC);

   // ************************************************************
   // parity computation
   // ************************************************************
   cap_pkg::cap_cmd_t masked;   // unconnected pins forced low
   logic              odd;      // odd total with parity bit
   logic [3:0]        lat;      // latency in clocks
   always_comb begin
      masked = CMD;
      for (int i = 0; i < cap_pkg::ADDR_W; i++) begin
         if (i >= USED_ADDR)
            masked.addr[i] = 1'b0;
      end
      if (USE_STACK == 0)
         masked.stack = '0;
      odd = ^{masked, PARITY_INPUT};
      unique case (PARITY_LATENCY)
         cap_pkg::LAT_4: lat = cap_pkg::CLK_4;
         cap_pkg::LAT_5: lat = cap_pkg::CLK_5;
         cap_pkg::LAT_6: lat = cap_pkg::CLK_6;
         cap_pkg::LAT_8: lat = cap_pkg::CLK_8;
         default:        lat = 4'h0;              // disabled or reserved
      endcase
   end

   // enabled only with the loop locked; reserved codes read as off
   wire logic par_en = DLL_ON && (lat != 4'h0);
   wire logic sel    = !CS_N;
   assign LAT_ADD = par_en ? lat : 4'h0;

   // ************************************************************
   // control state
   // ************************************************************
   cap_pkg::cap_state_t state, next_state;
   logic [cap_pkg::CNT_W-1:0] cnt, next_cnt;     // alert timer
   logic                      stat, next_stat;   // status bit
   logic                      pre, next_pre;     // precharge done
   cap_pkg::cap_cmd_t         log_q, next_log;
   logic                      crc_clr, next_crc_clr;
   logic                      pch, next_pch;
   logic                      err;

   // checking is live in run, or after release in persistent mode
   always_comb begin
      err = par_en && sel && odd && (state == cap_pkg::ST_RUN);
      next_state   = state;
      next_cnt     = cnt;
      next_stat    = stat;
      next_pre     = pre;
      next_log     = log_q;
      next_crc_clr = 1'b0;
      next_pch     = 1'b0;
      // controller can only clear; writes of one are blocked
      if (STATUS_WR && !STATUS_WDATA)
         next_stat = 1'b0;
      unique case (state)
         cap_pkg::ST_RUN: begin
            if (err) begin
               next_state   = cap_pkg::ST_ALERT;
               next_cnt     = '0;
               next_pre     = 1'b0;
               next_stat    = 1'b1;               // set wins over clear
               next_crc_clr = CRC_ON;
               if (!stat)
                  next_log = CMD;
            end
         end
         cap_pkg::ST_ALERT: begin
            next_cnt = cnt + 1'b1;
            // close pages once row time has passed
            if (cnt == ROW_C) begin
               next_pch = 1'b1;
               next_pre = 1'b1;
            end
            if (cnt >= MIN_C && pre)
               next_state = PERSIST ? cap_pkg::ST_RUN : cap_pkg::ST_SUSP;
         end
         cap_pkg::ST_SUSP: begin
            if (!next_stat || PERSIST)
               next_state = cap_pkg::ST_RUN;
         end
         default: next_state = cap_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state   <= cap_pkg::ST_RUN;
         cnt     <= '0;
         stat    <= 1'b0;
         pre     <= 1'b0;
         log_q   <= '0;
         crc_clr <= 1'b0;
         pch     <= 1'b0;
      end else if (CE) begin
         state   <= next_state;
         cnt     <= next_cnt;
         stat    <= next_stat;
         pre     <= next_pre;
         log_q   <= next_log;
         crc_clr <= next_crc_clr;
         pch     <= next_pch;
      end
   end

   // alert is decoded from the state register: low the edge after detection, well inside onset
   assign ALERT_N       = (state != cap_pkg::ST_ALERT);
   assign PARITY_STATUS = stat;
   assign CRC_ERR_CLEAR = crc_clr;
   assign PRECHARGE_ALL = pch;
   assign LOG_CMD       = log_q;

   // ************************************************************
   // hold line: each stage carries valid and command
   // ************************************************************
   logic              hv  [cap_pkg::MAX_LAT];
   cap_pkg::cap_cmd_t hc  [cap_pkg::MAX_LAT];
   logic              next_hv [cap_pkg::MAX_LAT];
   cap_pkg::cap_cmd_t next_hc [cap_pkg::MAX_LAT];
   logic              in_ok;
   logic              tap_v;
   cap_pkg::cap_cmd_t tap_c;

   // a failing command never enters; commands already in the hold line
   // are flushed; only the one at the tap on the detecting edge still executes, in the first alert cycle
   always_comb begin
      in_ok = sel && !err && (state != cap_pkg::ST_ALERT);
      next_hv[0] = in_ok;
      next_hc[0] = CMD;
      for (int i = 1; i < cap_pkg::MAX_LAT; i++) begin
         next_hv[i] = hv[i-1] && (state != cap_pkg::ST_ALERT);
         next_hc[i] = hc[i-1];
      end
      tap_v = 1'b0;
      tap_c = '0;
      if (lat != 4'h0 && par_en) begin
         tap_v = hv[lat[2:0] - 3'h1 + ((lat == cap_pkg::CLK_8) ? 3'h0 : 3'h0)];
         tap_c = hc[lat[2:0] - 3'h1];
         if (lat == cap_pkg::CLK_8) begin
            tap_v = hv[cap_pkg::MAX_LAT-1];
            tap_c = hc[cap_pkg::MAX_LAT-1];
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < cap_pkg::MAX_LAT; i++) begin
            hv[i] <= 1'b0;
            hc[i] <= '0;
         end
      end else if (CE) begin
         for (int i = 0; i < cap_pkg::MAX_LAT; i++) begin
            hv[i] <= next_hv[i];
            hc[i] <= next_hc[i];
         end
      end
   end

   // output register; direct path when parity is off
   logic              ev, next_ev;
   cap_pkg::cap_cmd_t ec, next_ec;
   always_comb begin
      next_ev = par_en ? tap_v : (sel && state != cap_pkg::ST_ALERT);
      next_ec = par_en ? tap_c : CMD;
      if (state == cap_pkg::ST_ALERT)
         next_ev = 1'b0;
   end
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ev <= 1'b0;
         ec <= '0;
      end else if (CE) begin
         ev <= next_ev;
         ec <= next_ec;
      end
   end
   assign EXEC_VALID = ev;
   assign EXEC_CMD   = ec;

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_err;
      err && CE;
   endsequence
   a_alert_onset: assert property (@(posedge CLK) disable iff (!RSTN)
      s_err |=> !ALERT_N) else $error("alert not low after error");
   a_status_set: assert property (@(posedge CLK) disable iff (!RSTN)
      s_err |=> PARITY_STATUS) else $error("status not set");
   a_alert_min: assert property (@(posedge CLK) disable iff (!RSTN)
      $rose(ALERT_N) |-> cnt >= MIN_C) else $error("alert too short");
   a_no_exec: assert property (@(posedge CLK) disable iff (!RSTN)
      !ALERT_N && $past(!ALERT_N) |-> !EXEC_VALID) else $error("exec in alert");
   a_crc_clear: assert property (@(posedge CLK) disable iff (!RSTN)
      (s_err and CRC_ON) |=> CRC_ERR_CLEAR) else $error("crc bit not cleared");
   a_log_keep: assert property (@(posedge CLK) disable iff (!RSTN)
      PARITY_STATUS && !err |=> $stable(LOG_CMD)) else $error("log changed");
   a_no_dll: assert property (@(posedge CLK) disable iff (!RSTN)
      !DLL_ON |-> !err) else $error("check without loop");
   a_lat_add: assert property (@(posedge CLK) disable iff (!RSTN)
      !DLL_ON |-> LAT_ADD == 4'h0) else $error("latency added without loop");
endmodule

/* rtl/cap_pkg.sv */
// package for the command/address parity checker
// assumes one 250 MHz command clock; all timing counts derive from it
package cap_pkg;
   // ************************************************************
   // widths and encodings
   // ************************************************************
   localparam int ADDR_W   = 14;                // plain address bits a[13:0]
   localparam int STACK_W  = 3;                 // stack bits
   localparam int LAT_W    = 3;                 // parity latency code width
   localparam int CNT_W    = 8;                 // alert timer width
   localparam logic [LAT_W-1:0] LAT_OFF  = 3'h0; // checking disabled
   localparam logic [LAT_W-1:0] LAT_4    = 3'h1; // 4 clocks
   localparam logic [LAT_W-1:0] LAT_5    = 3'h2; // 5 clocks
   localparam logic [LAT_W-1:0] LAT_6    = 3'h3; // 6 clocks
   localparam logic [LAT_W-1:0] LAT_8    = 3'h4; // 8 clocks
   localparam logic [3:0] CLK_4 = 4'h4;
   localparam logic [3:0] CLK_5 = 4'h5;
   localparam logic [3:0] CLK_6 = 4'h6;
   localparam logic [3:0] CLK_8 = 4'h8;
   localparam int MAX_LAT = 8;                   // deepest hold line

   // ************************************************************
   // timing, in ns, and derived cycle counts at 4 ns
   // ************************************************************
   localparam int CLK_PS          = 4000;        // clock period in ps
   localparam int ALERT_ON_NS     = 40;          // onset, longest
   localparam int ALERT_PW_MIN_NS = 160;         // pulse width, least
   localparam int ALERT_PW_MAX_NS = 400;         // pulse width, longest
   localparam int ROW_MIN_NS      = 32;          // row active min time
   localparam int ALERT_ON_CYC  = (ALERT_ON_NS * 1000) / CLK_PS;
   localparam int PW_MIN_CYC    = (ALERT_PW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int PW_MAX_CYC    = (ALERT_PW_MAX_NS * 1000) / CLK_PS;
   localparam int ROW_MIN_CYC   = (ROW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic               activate_flag;        // low means activate
      logic               row_strobe_addr16;
      logic               column_strobe_addr15;
      logic               write_strobe_addr14;
      logic               addr17;
      logic [1:0]         bank_group_select;
      logic [1:0]         bank;
      logic [ADDR_W-1:0]  addr;
      logic [STACK_W-1:0] stack;
   } cap_cmd_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,                          // normal checking
      ST_ALERT = 2'b01,                          // alert low, nothing executes after the first cycle
      ST_SUSP  = 2'b10                           // checking suspended
   } cap_state_t;
endpackage

/* bench/cap_ctrl_model.sv */
// controller model driving the command/address bus of the parity checker
// assumes one caller at a time; commands are launched on rising CLK
module cap_ctrl_model (
   input  wire logic         CLK,
   output cap_pkg::cap_cmd_t CMD,
   output logic              CS_N,
   output logic              PARITY_INPUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // bus idle
   // ************************************************************
   initial begin
      CS_N         = 1'b1; // deselected
      CMD          = '0;
      PARITY_INPUT = 1'b0;
   end
   // one selected cycle, then deselect with scrambled lines
   task automatic issue(input cap_pkg::cap_cmd_t c, input logic bad);
      @(posedge CLK);
      CS_N         <= 1'b0;
      CMD          <= c;
      PARITY_INPUT <= (^c) ^ bad; // even parity unless told to break it
      @(posedge CLK);
      CS_N         <= 1'b1; // only deselects between commands
      CMD          <= ~c; // stale value would hide a missing select check
      PARITY_INPUT <= ~((^c) ^ bad);
   endtask
endmodule

/* bench/command_address_parity_checker_tb.sv */
// self-checking bench for the command/address parity checker
// assumes cap_checker with default parameters and the controller model
module command_address_parity_checker_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // signals
   // ************************************************************
   logic              clk, rstn, dll_on, persist, status_wr, status_wdata, crc_on;
   logic [2:0]        lat;          // latency code
   logic              cs_n, par, exec_valid, alert_n, status, crc_clr, pre_all;
   cap_pkg::cap_cmd_t cmd, exec_cmd, log_cmd, c;
   logic [3:0]        lat_add;
   int                error_cnt, n_tests, cyc;

   cap_ctrl_model u_ctrl (.CLK(clk), .CMD(cmd), .CS_N(cs_n), .PARITY_INPUT(par));
   cap_checker u_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .DLL_ON(dll_on), .CS_N(cs_n), .CMD(cmd),
      .PARITY_INPUT(par), .PARITY_LATENCY(lat), .PERSIST(persist), .STATUS_WR(status_wr),
      .STATUS_WDATA(status_wdata), .CRC_ON(crc_on), .EXEC_VALID(exec_valid), .EXEC_CMD(exec_cmd),
      .ALERT_N(alert_n), .PARITY_STATUS(status), .CRC_ERR_CLEAR(crc_clr), .PRECHARGE_ALL(pre_all),
      .LOG_CMD(log_cmd), .LAT_ADD(lat_add));

   // 4 ns clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard; the whole run needs well under 3000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // ************************************************************
   // model and compares
   // ************************************************************
   function automatic int lat_clk(input logic [2:0] k);
      case (k)
         3'h1: return 4;
         3'h2: return 5;
         3'h3: return 6;
         3'h4: return 8;
         default: return 0; // reserved codes act as disabled
      endcase
   endfunction
   function automatic cap_pkg::cap_cmd_t rnd();
      logic [31:0] r;
      r = $urandom;
      return r[$bits(cap_pkg::cap_cmd_t)-1:0];
   endfunction
   task automatic chk_bit(input string n, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_cmd(input string n, input cap_pkg::cap_cmd_t e, input cap_pkg::cap_cmd_t g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // command must appear at the d-th edge, counting the taking edge as the first
   task automatic send_exec(input cap_pkg::cap_cmd_t x, input logic bad, input int d);
      u_ctrl.issue(x, bad);
      // the taking edge is the one at which issue returns
      for (int i = 1; i <= d; i++) begin
         #1;
         chk_bit("exec_valid", i == d, exec_valid);
         if (i < d)
            @(posedge clk);
      end
      chk_cmd("exec_cmd", x, exec_cmd);
      chk_bit("alert_n_quiet", 1'b1, alert_n);
   endtask
   // bad command: alert pulse, status, log, precharge, nothing executes
   task automatic err_seq(input cap_pkg::cap_cmd_t x, input logic crc, input logic logchk);
      int cnt, pre, ex;
      u_ctrl.issue(x, 1'b1);
      // crc clear pulse stands only in the cycle after the taking edge
      #1;
      chk_bit("alert_n_on", 1'b0, alert_n);
      chk_bit("status_set", 1'b1, status);
      chk_bit("crc_clear", crc, crc_clr);
      cnt = 1;
      pre = pre_all;
      ex  = exec_valid;
      while (alert_n === 1'b0 && cnt < 300) begin
         @(posedge clk);
         #1;
         cnt++;
         pre += pre_all;
         ex  += exec_valid;
      end
      chk_bit("alert_released", 1'b1, alert_n);
      chk_bit("width_min", 1'b1, cnt > cap_pkg::PW_MIN_CYC);
      chk_bit("width_max", 1'b1, cnt <= cap_pkg::ALERT_ON_CYC + cap_pkg::PW_MAX_CYC);
      chk_bit("one_precharge", 1'b1, pre == 1);
      chk_bit("no_exec", 1'b1, ex == 0);
      chk_bit("status_held", 1'b1, status);
      if (logchk) begin
         chk_cmd("log_cmd", x, log_cmd);
      end
      repeat (3) @(posedge clk); // deselects around release
   endtask
   task automatic wr_status(input logic v);
      @(posedge clk);
      status_wr    <= 1'b1;
      status_wdata <= v;
      @(posedge clk);
      status_wr    <= 1'b0;
      #1;
   endtask
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {rstn, status_wr, status_wdata, crc_on, persist, lat} = '0;
      dll_on = 1'b1;
      void'($urandom(32'hc7b4));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      // every latency code and one reserved, via disabled each time
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         lat <= 3'h0;
         @(posedge clk);
         lat <= k[2:0];
         @(posedge clk);
         #1;
         chk_bit("lat_add", 1'b1, lat_add === 4'(lat_clk(k[2:0])));
         send_exec(rnd(), 1'b0, lat_clk(k[2:0]) + 1);
      end
      @(posedge clk);
      lat    <= 3'h0;
      @(posedge clk);
      lat    <= 3'h3;
      crc_on <= 1'b1;
      c = rnd();
      err_seq(c, 1'b1, 1'b1);
      send_exec(rnd(), 1'b1, 7); // suspended: bad one runs
      chk_cmd("log_kept", c, log_cmd);
      wr_status(1'b1);
      chk_bit("status_no_set", 1'b1, status);
      wr_status(1'b0);
      chk_bit("status_clr", 1'b0, status);
      send_exec(rnd(), 1'b0, 7);
      err_seq(rnd(), 1'b1, 1'b1); // new log after clearing
      wr_status(1'b0);
      @(posedge clk);
      dll_on <= 1'b0;
      send_exec(rnd(), 1'b1, 1); // no checking, no latency without the loop
      dll_on  <= 1'b1;
      persist <= 1'b1;
      crc_on  <= 1'b0;
      err_seq(rnd(), 1'b0, 1'b1);
      err_seq(rnd(), 1'b0, 1'b0); // status still set, checking resumed
      @(posedge clk);
      lat <= 3'h0; // parity off before any power-saving entry
      @(posedge clk);
      summarize();
   end
endmodule
